// ---- nic_ctrl.sv ----
// Purpose: master-mode nested interrupt controller with APB registers
// Assumes: internal request inputs are one-cycle pulses on pclk
// Notes: request pins pass two flip-flops, nmi pin three; acknowledge takes five cycles
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - one non-maskable pin, four general pins
// - direct pins use internally made vectors
// - cascaded pins take vector from outside
// - two acknowledge cycles, vector caught second
// - internal sources same in every mode
// - service flag blocks lower priority sources
// - own service flag blocks new request
// - higher priority still preempts running routine
// - next highest flagged source resumes after clear
// - line zero pairs line two, one three
// - each pin pair set to cascade independently
// - external tree gives 128 sources, three levels
// - pass-through nesting bit in line zero/one control
// - pass-through pin requests despite own flag
// - pass-through acknowledge still sets service flag
// - internal sources maskable in controller
// - configuration bit 14 selects slave operation
// - simultaneous requests served one at a time
// - three-bit priority, lower value wins
// - nonspecific done clears highest flagged source
// - acknowledge or poll read sets service flag
module nic_ctrl
	import nic_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// internal sources
	input wire logic [2:0] timer_irq,
	input wire logic [1:0] dma_irq,
	// external pins
	input wire logic nmi_pin,
	input wire logic ext_request_line_zero,
	input wire logic ext_request_line_one,
	input wire logic line_two_or_ack_zero_i,
	output logic line_two_or_ack_zero_o,
	output logic line_two_or_ack_zero_oe,
	input wire logic line_three_or_ack_one_i,
	output logic line_three_or_ack_one_o,
	output logic line_three_or_ack_one_oe,
	input wire logic [7:0] ext_vector_bus,
	// processor core
	input wire logic vector_acknowledge_cycle,
	output logic cpu_int_req,
	output logic cpu_nmi_req,
	output logic [7:0] vector_out,
	output logic vector_valid
);
	nic_res_if rif();
	// apb state
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	// configuration
	logic [20:0] pri_reg;
	logic [6:0] msk_reg;
	logic [3:0] ltm_reg;
	logic [1:0] cas_reg;
	logic [1:0] sfn_reg;
	logic [2:0] pmsk_reg;
	logic slave_reg;
	// service and request state
	logic [6:0] is_reg;
	logic [6:0] is_next;
	logic [2:0] ireq_reg;
	logic [2:0] ireq_next;
	logic [3:0] xreq;
	logic [6:0] req_all;
	// acknowledge sequencer
	nic_ack_e ack_reg;
	nic_ack_e ack_next;
	logic [2:0] asrc_reg;
	logic aok_reg;
	logic aext_reg;
	logic [7:0] vec_reg;
	logic vval_reg;
	logic ireq_out_reg;
	logic l2o_reg;
	logic l3o_reg;
	logic nmi_s1_reg;
	logic nmi_s2_reg;
	logic nmi_reg;
	logic [7:0] xv_s1_reg;
	logic [7:0] xv_s2_reg;
	// decode wires
	logic [7:0] idx;
	logic aligned;
	logic acc_done;
	logic wr_done;
	logic rd_done;
	logic [7:0] ctl_off;
	logic ctl_hit;
	logic [2:0] ctl_src;
	logic mapped;
	logic [31:0] rd_data;
	logic [15:0] poll_word;
	logic ack_start;
	logic poll_take;
	logic take;
	logic [6:0] take_vec;
	logic [3:0] pin_clr;
	logic [3:0] pin_en;
	logic [4:0] eoi_src;
	logic [6:0] eoi_clr;
	logic ext_vec_src;
	logic ack_act;
	logic [31:0] ctl_word;

	// apb decode; offsets are register indices, byte address is four times
	assign idx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign acc_done = psel && penable && pready_reg;
	assign wr_done = acc_done && pwrite && !pslverr_reg;
	assign rd_done = acc_done && !pwrite && !pslverr_reg;
	assign ctl_off = idx - IDX_TCR;
	assign ctl_hit = (idx >= IDX_TCR) && (idx <= IDX_I3C) && !ctl_off[0];
	assign ctl_src = ctl_off[3:1];
	assign mapped = aligned && (idx >= IDX_CFG) && (idx <= IDX_I3C) &&
		!idx[0];

	// source view handed to the resolver
	assign pin_en = {~cas_reg[1], ~cas_reg[0], 2'b11};
	assign req_all = {xreq, ireq_reg};
	assign rif.isf = is_reg;
	assign rif.pri = pri_reg;
	assign rif.pass = {2'b00, sfn_reg, 3'b000};
	genvar g;
	generate
		for (g = 0; g < NIC_NSRC; g++) begin : g_cand
			// own flag blocks unless pass-through nesting is on
			assign rif.cand[g] = req_all[g] && !msk_reg[g] &&
				(pri_reg[3*g +: 3] <= pmsk_reg) &&
				!(is_reg[g] && !rif.pass[g]);
		end
	endgenerate

	nic_resolve u_res (
		.rif(rif)
	);

	nic_pin_sense u_pins (
		.pclk(pclk),
		.presetn(presetn),
		.pin_raw({line_three_or_ack_one_i, line_two_or_ack_zero_i,
			ext_request_line_one, ext_request_line_zero}),
		.ltm(ltm_reg),
		.en(pin_en),
		.clr(pin_clr),
		.req(xreq)
	);

	// poll word: request bit plus vector of the current winner
	assign poll_word = {rif.win_ok, 10'h000,
		VEC_BASE + {2'b00, rif.win_idx}};

	// control word for one source; cascade bits only on lines zero, one
	always_comb begin
		ctl_word = 32'h0000_0000;
		ctl_word[2:0] = pri_reg[3*ctl_src +: 3];
		ctl_word[CTL_MSK_BIT] = msk_reg[ctl_src];
		if (ctl_src >= SRC_I0) begin
			ctl_word[CTL_LTM_BIT] = ltm_reg[2'(ctl_src - SRC_I0)];
		end
		if (ctl_src == SRC_I0 || ctl_src == SRC_I1) begin
			ctl_word[CTL_CAS_BIT] = cas_reg[ctl_src[0] ? 1'b0 : 1'b1];
			ctl_word[CTL_SFN_BIT] = sfn_reg[ctl_src[0] ? 1'b0 : 1'b1];
		end
	end

	// read data selection
	always_comb begin
		rd_data = 32'h0000_0000;
		if (idx == IDX_CFG) begin
			rd_data[CFG_SLAVE_BIT] = slave_reg;
		end else if (idx == IDX_POLL || idx == IDX_PSTAT) begin
			rd_data[15:0] = poll_word;
		end else if (idx == IDX_MASK) begin
			rd_data[15:0] = nic_map7(msk_reg);
		end else if (idx == IDX_PMASK) begin
			rd_data[2:0] = pmsk_reg;
		end else if (idx == IDX_INSRV) begin
			rd_data[15:0] = nic_map7(is_reg);
		end else if (idx == IDX_REQ) begin
			rd_data[15:0] = nic_map7(req_all);
		end else if (ctl_hit) begin
			rd_data = ctl_word;
		end
	end

	// apb answer: one wait state, read data captured with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && !mapped;
			if (psel && penable && !pready_reg && !pwrite) begin
				prdata_reg <= mapped ? rd_data : 32'h0000_0000;
			end
		end
	end

	// taking a request: acknowledge start or a poll read
	assign ack_start = (ack_reg == ACK_IDLE) && vector_acknowledge_cycle;
	assign poll_take = rd_done && (idx == IDX_POLL) && rif.win_ok;
	assign take = (ack_start && rif.win_ok) || poll_take;
	assign take_vec = take ? 7'(7'h01 << rif.win_idx) : 7'h00;
	assign pin_clr = take_vec[6:3];

	// service done: nonspecific clears top flag, specific names a vector
	assign eoi_src = pwdata[4:0] - VEC_BASE;
	always_comb begin
		eoi_clr = 7'h00;
		if (wr_done && idx == IDX_EOI) begin
			if (pwdata[EOI_NSPEC_BIT] && rif.top_any) begin
				eoi_clr[rif.top_idx] = 1'b1;
			end else if (!pwdata[EOI_NSPEC_BIT] && eoi_src < 5'd7) begin
				eoi_clr[eoi_src[2:0]] = 1'b1;
			end
		end
	end

	// flags: direct write, then clear, then hardware set wins
	always_comb begin
		is_next = is_reg;
		if (wr_done && idx == IDX_INSRV) begin
			is_next = nic_unmap7(pwdata);
		end
		is_next = (is_next & ~eoi_clr) | take_vec;
	end

	// internal requests; dma bits writable, timers are one flag
	always_comb begin
		ireq_next = ireq_reg;
		if (wr_done && idx == IDX_REQ) begin
			ireq_next[2:1] = pwdata[3:2];
		end
		ireq_next = ireq_next & ~take_vec[2:0];
		ireq_next = ireq_next | {dma_irq, |timer_irq};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			is_reg <= 7'h00;
			ireq_reg <= 3'h0;
		end else begin
			is_reg <= is_next;
			ireq_reg <= ireq_next;
		end
	end

	// configuration registers; mask shared with control words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pri_reg <= {NIC_NSRC{PRI_RST}};
			msk_reg <= MSK_RST;
			ltm_reg <= 4'h0;
			cas_reg <= 2'h0;
			sfn_reg <= 2'h0;
			pmsk_reg <= PMSK_RST;
			slave_reg <= 1'b0;
		end else if (wr_done) begin
			if (idx == IDX_CFG) begin
				slave_reg <= pwdata[CFG_SLAVE_BIT];
			end else if (idx == IDX_MASK) begin
				msk_reg <= nic_unmap7(pwdata);
			end else if (idx == IDX_PMASK) begin
				pmsk_reg <= pwdata[2:0];
			end else if (ctl_hit) begin
				pri_reg[3*ctl_src +: 3] <= pwdata[2:0];
				msk_reg[ctl_src] <= pwdata[CTL_MSK_BIT];
				if (ctl_src >= SRC_I0) begin
					ltm_reg[2'(ctl_src - SRC_I0)] <= pwdata[CTL_LTM_BIT];
				end
				if (ctl_src == SRC_I0 || ctl_src == SRC_I1) begin
					cas_reg[ctl_src[0] ? 1'b0 : 1'b1] <=
						pwdata[CTL_CAS_BIT];
					sfn_reg[ctl_src[0] ? 1'b0 : 1'b1] <=
						pwdata[CTL_SFN_BIT];
				end
			end
		end
	end

	// vector comes from outside for a cascaded or pass-through line
	assign ext_vec_src = (rif.win_idx == SRC_I0 && (cas_reg[0] ||
		sfn_reg[0])) || (rif.win_idx == SRC_I1 && (cas_reg[1] ||
		sfn_reg[1]));

	// acknowledge sequencer: two bus cycles, then the settle of the sync
	always_comb begin
		ack_next = ack_reg;
		case (ack_reg)
			ACK_IDLE: begin
				if (vector_acknowledge_cycle) begin
					ack_next = ACK_FIRST;
				end
			end
			ACK_FIRST: begin
				ack_next = ACK_SECOND;
			end
			ACK_SECOND: begin
				ack_next = ACK_SETTLE;
			end
			ACK_SETTLE: begin
				ack_next = ACK_DONE;
			end
			default: begin
				ack_next = ACK_IDLE;
			end
		endcase
	end
	assign ack_act = (ack_next == ACK_FIRST) || (ack_next == ACK_SECOND);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg <= ACK_IDLE;
			asrc_reg <= 3'h0;
			aok_reg <= 1'b0;
			aext_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
			if (ack_start) begin
				asrc_reg <= rif.win_idx;
				aok_reg <= rif.win_ok;
				aext_reg <= rif.win_ok && ext_vec_src;
			end
		end
	end

	// acknowledge strobes are active low on the paired pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			l2o_reg <= 1'b1;
			l3o_reg <= 1'b1;
		end else begin
			l2o_reg <= !(ack_act && (ack_start ? ext_vec_src &&
				rif.win_ok && rif.win_idx == SRC_I0 : aext_reg &&
				asrc_reg == SRC_I0));
			l3o_reg <= !(ack_act && (ack_start ? ext_vec_src &&
				rif.win_ok && rif.win_idx == SRC_I1 : aext_reg &&
				asrc_reg == SRC_I1));
		end
	end

	// external vector bus is foreign: two stages before capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xv_s1_reg <= 8'h00;
			xv_s2_reg <= 8'h00;
			nmi_s1_reg <= 1'b0;
			nmi_s2_reg <= 1'b0;
			nmi_reg <= 1'b0;
		end else begin
			xv_s1_reg <= ext_vector_bus;
			xv_s2_reg <= xv_s1_reg;
			nmi_s1_reg <= nmi_pin;
			nmi_s2_reg <= nmi_s1_reg;
			nmi_reg <= nmi_s2_reg;
		end
	end

	// vector delivery in done: only then has second-cycle bus data
	// cleared both sync stages; one cycle earlier holds first-cycle data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_reg <= 8'h00;
			vval_reg <= 1'b0;
			ireq_out_reg <= 1'b0;
		end else begin
			vval_reg <= (ack_reg == ACK_DONE);
			if (ack_reg == ACK_DONE) begin
				if (!aok_reg) begin
					vec_reg <= VEC_SPUR;
				end else if (aext_reg) begin
					vec_reg <= xv_s2_reg;
				end else begin
					vec_reg <= {3'h0, VEC_BASE + {2'b00, asrc_reg}};
				end
			end
			// slave operation silences the master request path
			ireq_out_reg <= rif.win_ok && !slave_reg &&
				(ack_reg == ACK_IDLE) && !ack_start;
		end
	end

	// outputs straight from flip-flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign cpu_int_req = ireq_out_reg;
	assign cpu_nmi_req = nmi_reg;
	assign vector_out = vec_reg;
	assign vector_valid = vval_reg;
	assign line_two_or_ack_zero_o = l2o_reg;
	assign line_three_or_ack_one_o = l3o_reg;
	assign line_two_or_ack_zero_oe = cas_reg[0];
	assign line_three_or_ack_one_oe = cas_reg[1];
endmodule // nic_ctrl

// ---- nic_pkg.sv ----
// Purpose: shared constants, types and helpers of the interrupt controller
// Assumes: register byte address is four times the register index
// Notes: source order is timer, dma0, dma1, line0..line3
package nic_pkg;
	localparam int NIC_NSRC = 7;
	// source indices
	localparam logic [2:0] SRC_TMR = 3'h0;
	localparam logic [2:0] SRC_I0 = 3'h3;
	localparam logic [2:0] SRC_I1 = 3'h4;
	// register indices
	localparam logic [7:0] IDX_CFG = 8'h20;
	localparam logic [7:0] IDX_EOI = 8'h22;
	localparam logic [7:0] IDX_POLL = 8'h24;
	localparam logic [7:0] IDX_PSTAT = 8'h26;
	localparam logic [7:0] IDX_MASK = 8'h28;
	localparam logic [7:0] IDX_PMASK = 8'h2a;
	localparam logic [7:0] IDX_INSRV = 8'h2c;
	localparam logic [7:0] IDX_REQ = 8'h2e;
	localparam logic [7:0] IDX_STAT = 8'h30;
	localparam logic [7:0] IDX_TCR = 8'h32;
	localparam logic [7:0] IDX_I3C = 8'h3e;
	// field positions
	localparam int CTL_MSK_BIT = 3;
	localparam int CTL_LTM_BIT = 4;
	localparam int CTL_CAS_BIT = 5;
	localparam int CTL_SFN_BIT = 6;
	localparam int CFG_SLAVE_BIT = 14;
	localparam int EOI_NSPEC_BIT = 15;
	localparam int POLL_REQ_BIT = 15;
	// reset values
	localparam logic [2:0] PRI_RST = 3'h7;
	localparam logic [6:0] MSK_RST = 7'h7f;
	localparam logic [2:0] PMSK_RST = 3'h7;
	// vectors; base and spurious value are arbitrary
	localparam logic [4:0] VEC_BASE = 5'h08;
	localparam logic [7:0] VEC_SPUR = 8'hff;
	typedef enum logic [2:0] {
		ACK_IDLE = 3'h0,
		ACK_FIRST = 3'h1,
		ACK_SECOND = 3'h3,
		ACK_SETTLE = 3'h2,
		ACK_DONE = 3'h6
	} nic_ack_e;
	// rank key: smaller wins, ties broken by source index
	function automatic logic [5:0] nic_key(logic [2:0] pri, logic [2:0] s);
		return {pri, s};
	endfunction
	// 7 source bits to register view (bit 1 unused)
	function automatic logic [15:0] nic_map7(logic [6:0] v);
		return {8'h00, v[6:1], 1'b0, v[0]};
	endfunction
	function automatic logic [6:0] nic_unmap7(logic [31:0] w);
		return {w[7:2], w[0]};
	endfunction
endpackage

// ---- nic_res_if.sv ----
// Purpose: carrier between control logic and priority resolver
// Assumes: one clock domain, purely combinational resolver
// Notes: pri packs three bits per source, source 0 lowest
`timescale 1ns/1ns
interface nic_res_if;
	logic [6:0] cand;
	logic [6:0] isf;
	logic [6:0] pass;
	logic [20:0] pri;
	logic win_any;
	logic win_ok;
	logic [2:0] win_idx;
	logic top_any;
	logic [2:0] top_idx;
	modport ctl(output cand, isf, pass, pri,
		input win_any, win_ok, win_idx, top_any, top_idx);
	modport res(input cand, isf, pass, pri,
		output win_any, win_ok, win_idx, top_any, top_idx);
endinterface

// ---- nic_resolve.sv ----
// Purpose: picks best pending source and best in-service source
// Assumes: candidates already masked and gated by own service flag
// Notes: win_ok tells whether the winner may reach the processor
`timescale 1ns/1ns
module nic_resolve
	import nic_pkg::*;
(
	nic_res_if.res rif
);
	// linear search; seven sources keep the chain short
	always_comb begin
		logic [5:0] kw;
		logic [5:0] kt;
		logic [5:0] k;
		logic ok;
		kw = 6'h3f;
		kt = 6'h3f;
		k = 6'h00;
		ok = 1'b1;
		rif.win_any = 1'b0;
		rif.win_idx = 3'h0;
		rif.top_any = 1'b0;
		rif.top_idx = 3'h0;
		for (int i = 0; i < NIC_NSRC; i++) begin
			k = nic_key(rif.pri[3*i +: 3], 3'(i));
			if (rif.cand[i] && (!rif.win_any || k < kw)) begin
				kw = k;
				rif.win_any = 1'b1;
				rif.win_idx = 3'(i);
			end
			if (rif.isf[i] && (!rif.top_any || k < kt)) begin
				kt = k;
				rif.top_any = 1'b1;
				rif.top_idx = 3'(i);
			end
		end
		// every active service flag except the winner's own pass-through flag must be outranked by the winner
		for (int i = 0; i < NIC_NSRC; i++) begin
			k = nic_key(rif.pri[3*i +: 3], 3'(i));
			if (rif.isf[i] && !(3'(i) == rif.win_idx && rif.pass[i]) &&
				!(kw < k))
				ok = 1'b0;
		end
		rif.win_ok = rif.win_any && ok;
	end
endmodule // nic_resolve

// ---- nic_pin_sense.sv ----
// Purpose: synchronises the four request pins, edge or level sense
// Assumes: pins are asynchronous to pclk, active high
// Notes: an edge latch re-arms only after the pin has been low
`timescale 1ns/1ns
module nic_pin_sense (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins and control
	input wire logic [3:0] pin_raw,
	input wire logic [3:0] ltm,
	input wire logic [3:0] en,
	input wire logic [3:0] clr,
	// request view
	output logic [3:0] req
);
	logic [3:0] s1_reg;
	logic [3:0] s2_reg;
	logic [3:0] s3_reg;
	logic [3:0] lat_reg;
	logic [3:0] rise;
	logic [3:0] lat_next;
	assign rise = s2_reg & ~s3_reg;
	// set beats acknowledge clear in the same cycle
	assign lat_next = ((lat_reg & ~clr) | rise) & en;
	assign req = en & ((ltm & s2_reg) | (~ltm & lat_reg));
	// two-stage synchroniser, third stage only for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 4'h0;
			s2_reg <= 4'h0;
			s3_reg <= 4'h0;
			lat_reg <= 4'h0;
		end else begin
			s1_reg <= pin_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lat_reg <= lat_next;
		end
	end
endmodule // nic_pin_sense

// ---- nic_ctrl_props.sv ----
// Purpose: port-level checks of the interrupt controller
// Assumes: single clock, asynchronous active-low reset
// Notes: busy_reg follows one accepted acknowledge sequence
`timescale 1ns/1ns
module nic_ctrl_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb answer
	input wire logic pready,
	input wire logic pslverr,
	// core side
	input wire logic nmi_pin,
	input wire logic cpu_nmi_req,
	input wire logic vector_acknowledge_cycle,
	input wire logic vector_valid,
	input wire logic cpu_int_req,
	// cascade strobe
	input wire logic line_two_or_ack_zero_o,
	input wire logic line_two_or_ack_zero_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic busy_reg;
	// pulses inside a sequence are ignored, so only idle ones count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_reg <= 1'b0;
		else if (vector_valid)
			busy_reg <= 1'b0;
		else if (vector_acknowledge_cycle)
			busy_reg <= 1'b1;
	end
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once)
		else $error("pready longer than one cycle");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("pslverr without pready");
	property p_ack_two;
		$fell(line_two_or_ack_zero_o) |=>
			!line_two_or_ack_zero_o ##1 line_two_or_ack_zero_o;
	endproperty
	a_ack_two: assert property (p_ack_two)
		else $error("acknowledge strobe not two cycles");
	property p_ack_oe;
		!line_two_or_ack_zero_o |-> line_two_or_ack_zero_oe;
	endproperty
	a_ack_oe: assert property (p_ack_oe)
		else $error("acknowledge strobe while pin not driven");
	property p_ack_len;
		vector_acknowledge_cycle && !busy_reg |-> ##[3:6] vector_valid;
	endproperty
	a_ack_len: assert property (p_ack_len)
		else $error("no vector after acknowledge");
	property p_quiet;
		busy_reg && $past(busy_reg) && !vector_valid |-> !cpu_int_req;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("request raised during acknowledge");
	property p_valid_once;
		vector_valid |=> !vector_valid;
	endproperty
	a_valid_once: assert property (p_valid_once)
		else $error("vector_valid longer than one cycle");
	property p_nmi;
		$rose(cpu_nmi_req) |-> $past(nmi_pin, 3);
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("nmi request without pin");
	c_cascade: cover property ($fell(line_two_or_ack_zero_o));
	c_refused: cover property (pslverr);
	c_nmi: cover property ($rose(cpu_nmi_req));
endmodule // nic_ctrl_props
bind nic_ctrl nic_ctrl_props nic_ctrl_props_inst (
	.pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
	.nmi_pin(nmi_pin), .cpu_nmi_req(cpu_nmi_req),
	.vector_acknowledge_cycle(vector_acknowledge_cycle),
	.vector_valid(vector_valid), .cpu_int_req(cpu_int_req),
	.line_two_or_ack_zero_o(line_two_or_ack_zero_o),
	.line_two_or_ack_zero_oe(line_two_or_ack_zero_oe)
);

// ---- nic_ext_pic.sv ----
// Purpose: behavioural outside cascaded controller on line zero
// Assumes: acknowledge strobe active low, two low cycles per sequence
// Notes: bus toggles whenever no vector is presented
`timescale 1ns/1ns
module nic_ext_pic #(
	parameter logic [7:0] vec_value = 8'h47
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench command and controller side
	input wire logic raise,
	input wire logic ack_n,
	output logic req,
	output logic [7:0] vec
);
	logic seen_reg;
	logic [1:0] hold_reg;
	// request stays up until the first strobe cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			req <= 1'b0;
		else if (raise)
			req <= 1'b1;
		else if (!ack_n)
			req <= 1'b0;
	end
	// vector from the second strobe cycle for three clocks, else noise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_reg <= 1'b0;
			hold_reg <= 2'h0;
			vec <= 8'h00;
		end else begin
			seen_reg <= !ack_n;
			if (!ack_n && !seen_reg) begin
				hold_reg <= 2'h3;
				vec <= vec_value;
			end else if (hold_reg > 2'h1)
				hold_reg <= hold_reg - 2'h1;
			else begin
				hold_reg <= 2'h0;
				vec <= ~vec;
			end
		end
	end
endmodule // nic_ext_pic

// ---- nested_interrupt_controller_master_tb.sv ----
// Purpose: self-checking bench for the nested interrupt controller
// Assumes: apb answers with one wait state; partner on line zero
// Notes: scenarios run back to back after one reset
`timescale 1ns/1ns
module nested_interrupt_controller_master_tb import nic_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [2:0] timer_irq;
	logic [1:0] dma_irq;
	logic nmi_pin, line1, ack, raise, req0, l2o, l2oe, l3o, l3oe;
	logic int_req, nmi_req, valid;
	logic [7:0] ext_vec, vec_out;
	int n_errors = 0;
	int checks_done = 0;
	// a driven pin reads back its own level, otherwise held low
	wire l2_pin = l2oe ? l2o : 1'b0;
	wire l3_pin = l3oe ? l3o : 1'b0;
	nic_ctrl nic_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_irq(timer_irq), .dma_irq(dma_irq), .nmi_pin(nmi_pin),
		.ext_request_line_zero(req0), .ext_request_line_one(line1),
		.line_two_or_ack_zero_i(l2_pin), .line_two_or_ack_zero_o(l2o),
		.line_two_or_ack_zero_oe(l2oe), .line_three_or_ack_one_i(l3_pin),
		.line_three_or_ack_one_o(l3o), .line_three_or_ack_one_oe(l3oe),
		.ext_vector_bus(ext_vec), .vector_acknowledge_cycle(ack),
		.cpu_int_req(int_req), .cpu_nmi_req(nmi_req), .vector_out(vec_out),
		.vector_valid(valid));
	nic_ext_pic nic_ext_pic_inst (.pclk(pclk), .presetn(presetn),
		.raise(raise), .ack_n(l2_pin), .req(req0), .vec(ext_vec));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// a wait that runs out ends the run
	task stop;
		chk(32'h0, 32'h1);
		conclude;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		tick(1);
		penable <= 1'b1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			stop;
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask
	task wait_int;
		int n;
		n = 0;
		while (int_req !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		if (n >= 40)
			stop;
	endtask
	// acknowledge pulse, then vector taken at the valid edge
	task do_ack;
		int n;
		ack <= 1'b1;
		tick(1);
		ack <= 1'b0;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (valid !== 1'b1 && n < 10);
		if (n >= 10)
			stop;
	endtask
	task pulse(input logic [2:0] t, input logic [1:0] d);
		timer_irq <= t;
		dma_irq <= d;
		tick(1);
		timer_irq <= 3'h0;
		dma_irq <= 2'h0;
		tick(4);
	endtask
	task t_reset;
		apb(0, IDX_MASK, 0); chk(rdv, 32'h000000fd);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h0);
		apb(0, IDX_REQ, 0); chk(rdv, 32'h0);
		apb(0, IDX_TCR, 0); chk(rdv, 32'h0000000f);
		apb(0, 8'h10, 0); chk(err, 1'b1);
		chk(rdv, 32'h0);
		chk({l2oe, l2o}, 2'h1);
		chk({l3oe, l3o}, 2'h1);
		$display("test reset done");
	endtask
	task t_nest;
		apb(1, 8'h34, 32'h3);
		apb(1, 8'h36, 32'h1);
		apb(1, IDX_TCR, 32'h0);
		apb(1, IDX_MASK, 32'h0c);
		pulse(3'h0, 2'h3); chk(int_req, 1'b0);
		apb(0, IDX_REQ, 0); chk(rdv, 32'h0c);
		apb(1, IDX_MASK, 32'h0);
		wait_int; do_ack; chk(vec_out, 8'h0a);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h08);
		tick(4); chk(int_req, 1'b0);
		pulse(3'h1, 2'h0); wait_int; do_ack; chk(vec_out, 8'h08);
		apb(1, IDX_EOI, 32'h8000);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h08);
		tick(4); chk(int_req, 1'b0);
		apb(1, IDX_EOI, 32'h0a);
		wait_int; do_ack; chk(vec_out, 8'h09);
		apb(1, IDX_EOI, 32'h8000);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h0);
		$display("test nesting done");
	endtask
	task t_cascade;
		apb(1, 8'h38, 32'h22); chk({l2oe, l3oe}, 2'h2);
		raise <= 1'b1;
		tick(1);
		raise <= 1'b0;
		wait_int; do_ack; chk(vec_out, 8'h47);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h10);
		raise <= 1'b1;
		tick(1);
		raise <= 1'b0;
		tick(6); chk(int_req, 1'b0);
		apb(1, 8'h38, 32'h62);
		wait_int; do_ack; chk(vec_out, 8'h47);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h10);
		pulse(3'h0, 2'h1); chk(int_req, 1'b0);
		// outer level still open, so one command clears the local flag
		apb(1, IDX_EOI, 32'h0b);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h0);
		wait_int; do_ack; chk(vec_out, 8'h09);
		apb(1, IDX_EOI, 32'h8000);
		$display("test cascade done");
	endtask
	task t_direct;
		apb(1, 8'h3a, 32'h04); chk(l3oe, 1'b0);
		line1 <= 1'b1;
		wait_int; apb(0, IDX_PSTAT, 0); chk(rdv, 32'h800c);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h0);
		apb(0, IDX_POLL, 0); chk(rdv, 32'h800c);
		apb(0, IDX_INSRV, 0); chk(rdv, 32'h20);
		apb(1, IDX_EOI, 32'h8000);
		tick(6); chk(int_req, 1'b0);
		apb(1, IDX_CFG, 32'h4000);
		line1 <= 1'b0;
		tick(2);
		line1 <= 1'b1;
		tick(6); chk(int_req, 1'b0);
		apb(1, IDX_CFG, 32'h0);
		wait_int; do_ack; chk(vec_out, 8'h0c);
		apb(1, IDX_EOI, 32'h8000);
		nmi_pin <= 1'b1;
		tick(5); chk(nmi_req, 1'b1);
		nmi_pin <= 1'b0;
		tick(5); chk(nmi_req, 1'b0);
		$display("test direct done");
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, nmi_pin, line1, ack, raise} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		timer_irq = 3'h0;
		dma_irq = 2'h0;
		tick(20);
		presetn <= 1'b1;
		tick(1);
		t_reset;
		t_nest;
		t_cascade;
		t_direct;
		conclude;
	end
	// hang guard
	initial begin
		tick(20000);
		stop;
	end
endmodule // nested_interrupt_controller_master_tb
